// ### include/flash_access_pkg.sv
// Constants, register map and state types for the flash access control register bank
package flash_access_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ACCESS_SIZE = 8'h00;
  localparam logic [7:0] OFS_READ_WAIT   = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;
  localparam logic [7:0] OFS_EXTRA_WAIT  = 8'h0C;
  localparam logic [7:0] OFS_TRACE_CTRL  = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h14;
  localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h1C;

  // ----------------------------------------------------------------
  // Field codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ASZ_PROG   = 2'h1;
  localparam logic [1:0] ASZ_ROM    = 2'h2;
  localparam logic [1:0] ASZ_RESET  = 2'h2;
  localparam logic [1:0] RWT_ZERO   = 2'h0;
  localparam logic [1:0] RWT_ACC0   = 2'h2;
  localparam logic [1:0] RWT_ACC1   = 2'h3;
  localparam logic [1:0] RWT_RESET  = 2'h3;
  localparam logic [2:0] SD_RESET   = 3'h0;
  localparam logic [2:0] IE_RESET   = 3'h0;
  localparam logic [2:0] FLAG_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Bit positions: status, flags, enables and clears share a layout
  // ----------------------------------------------------------------
  localparam int unsigned SRC_READY   = 0;
  localparam int unsigned SRC_HANG    = 1;
  localparam int unsigned SRC_ECC     = 2;
  localparam int unsigned NUM_SRC     = 3;
  localparam int unsigned TB_EN_BIT   = 0;
  localparam int unsigned TB_STAT_BIT = 1;

  // ----------------------------------------------------------------
  // Trace buffer initialisation timing
  // ----------------------------------------------------------------
  localparam int unsigned TRACE_INIT_CYCLES = 1025;
  localparam int unsigned CNT_W             = 11;
  localparam logic [10:0] TRACE_INIT_LAST   = 11'(TRACE_INIT_CYCLES - 1);
  localparam logic [10:0] CNT_ZERO          = 11'h000;
  localparam logic [10:0] CNT_ONE           = 11'h001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TB_OFF, TB_INIT, TB_ON} tb_state_t;

  typedef struct packed {
    logic [1:0]  access_size_field;
    logic [1:0]  read_wait_field;
    logic [2:0]  sd;
    logic [2:0]  ie;
    logic [2:0]  flags;
    logic [2:0]  stat;
    logic [2:0]  stat_prev;
    tb_state_t   tb;
    logic [10:0] init_cnt;
    logic        inval;
    logic [7:0]  rdata;
  } regs_t;

endpackage

// ### hdl/flash_access_control.sv
// Flash access control register bank: modes, waits, trace buffer, status and interrupts
//
// Function
// RULE1 - After reset the access size is 10, 32-bit read mode.
// RULE2 - Access size 01 is programming mode, 10 read mode; 00/11 never written.
// RULE3 - Host writes flash only as half-words in programming mode.
// RULE4 - Host changes access size only from code outside the flash.
// RULE5 - Host dummy-reads a changed configuration register before relying on it.
// RULE6 - Programming mode forces trace buffer status and enable to zero.
// RULE7 - Read wait 00 zero-wait, 10 accelerator 0, 11 accelerator 1; reset 11.
// RULE8 - Host picks read wait mode to suit the bus clock rate.
// RULE9 - Read wait setting acts only in 32-bit read mode.
// RULE10 - Data buffer is available in either accelerator mode.
// RULE11 - ECC status bit sets on correction; write 0 clears, 1 keeps.
// RULE12 - Status bit 1 shows the hang state, read-only, resets to 0.
// RULE13 - Host issues reset command on hang and discards the first read.
// RULE14 - Status bit 0 is low while an automatic operation runs.
// RULE15 - Host ignores the first ready read after an algorithm command.
// RULE16 - Extra wait codes 000,001,011,101,111 give 0,1,3,5,7 waits.
// RULE17 - Extra waits apply only in zero-wait mode, ignored in accelerator modes.
// RULE18 - Writing enable 1 starts init; after 1025 cycles status becomes 1.
// RULE19 - Prefetch keeps working during init; tracing starts once status is 1.
// RULE20 - Status reads 0 while stopped or initialising; enable 0 stops it.
// RULE21 - Each source interrupts when its flag and its enable are both 1.
// RULE22 - Reserved bits read as undefined and ignore writes.
// RULE23 - Each flag sets on the rising edge of its status signal.
// RULE24 - Writing 1 to a clear bit resets that flag; clears read 0.
// RULE25 - Rewriting access size or read wait invalidates the data buffer.
// RULE26 - Everything runs on the bus clock and loads reset values on reset.
`timescale 1ns/1ps

module flash_access_control (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Flash array status
  input  wire logic        ecc_corr_event,
  input  wire logic        hang_in,
  input  wire logic        ready_in,
  // Mode outputs to the flash interface
  output logic             prog_mode,
  output logic             rom_mode,
  output logic      [1:0]  read_wait_mode,
  output logic      [2:0]  extra_wait_count,
  output logic             prefetch_enable,
  output logic             data_buf_enable,
  output logic             data_buf_invalidate,
  output logic             trace_buf_init,
  output logic             trace_buf_active,
  // Interrupt requests
  output logic      [2:0]  irq_sources,
  output logic             flash_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  flash_access_pkg::regs_t s_r;
  flash_access_pkg::regs_t s_nxt;

  logic       wr_asz;
  logic       wr_rwt;
  logic       wr_stat;
  logic       wr_sd;
  logic       wr_tb;
  logic       wr_ie;
  logic       wr_clr;
  logic       accel_sel;
  logic       zero_sel;

  assign wr_asz  = wr && (addr == flash_access_pkg::OFS_ACCESS_SIZE);
  assign wr_rwt  = wr && (addr == flash_access_pkg::OFS_READ_WAIT);
  assign wr_stat = wr && (addr == flash_access_pkg::OFS_STATUS);
  assign wr_sd   = wr && (addr == flash_access_pkg::OFS_EXTRA_WAIT);
  assign wr_tb   = wr && (addr == flash_access_pkg::OFS_TRACE_CTRL);
  assign wr_ie   = wr && (addr == flash_access_pkg::OFS_IRQ_ENABLE);
  assign wr_clr  = wr && (addr == flash_access_pkg::OFS_IRQ_CLEAR);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt       = s_r;
    s_nxt.rdata = 8'h00;
    s_nxt.inval = 1'b0;
    // RULE2 - access size store
    if (wr_asz) begin
      s_nxt.access_size_field   = wdata[1:0];
      // RULE25 - invalidate on rewrite
      s_nxt.inval = 1'b1;
    end
    // RULE7 - read wait store
    if (wr_rwt) begin
      s_nxt.read_wait_field   = wdata[1:0];
      s_nxt.inval = 1'b1;
    end
    // RULE16 - extra wait store
    if (wr_sd) begin
      s_nxt.sd = wdata[2:0];
    end
    // RULE21 - interrupt enables
    if (wr_ie) begin
      s_nxt.ie = wdata[2:0];
    end
    // RULE12 - hang and ready follow the array
    s_nxt.stat[flash_access_pkg::SRC_HANG]  = hang_in;
    // RULE14 - ready low while busy
    s_nxt.stat[flash_access_pkg::SRC_READY] = ready_in;
    // RULE11 - ECC bit, set wins over clear
    if (wr_stat && !wdata[flash_access_pkg::SRC_ECC]) begin
      s_nxt.stat[flash_access_pkg::SRC_ECC] = 1'b0;
    end
    if (ecc_corr_event) begin
      s_nxt.stat[flash_access_pkg::SRC_ECC] = 1'b1;
    end
    s_nxt.stat_prev = s_r.stat;
    for (int i = 0; i < flash_access_pkg::NUM_SRC; i++) begin
      // RULE24 - clear by writing one
      if (wr_clr && wdata[i]) begin
        s_nxt.flags[i] = 1'b0;
      end
      // RULE23 - rising edge sets, wins over clear
      if (s_r.stat[i] && !s_r.stat_prev[i]) begin
        s_nxt.flags[i] = 1'b1;
      end
    end
    // RULE18 - trace buffer enable and init
    unique case (s_r.tb)
      flash_access_pkg::TB_OFF: begin
        if (wr_tb && wdata[flash_access_pkg::TB_EN_BIT]) begin
          s_nxt.tb       = flash_access_pkg::TB_INIT;
          s_nxt.init_cnt = flash_access_pkg::CNT_ZERO;
        end
      end
      flash_access_pkg::TB_INIT: begin
        // RULE20 - enable 0 stops
        if (wr_tb && !wdata[flash_access_pkg::TB_EN_BIT]) begin
          s_nxt.tb = flash_access_pkg::TB_OFF;
        end else if (s_r.init_cnt == flash_access_pkg::TRACE_INIT_LAST) begin
          s_nxt.tb = flash_access_pkg::TB_ON;
        end else begin
          s_nxt.init_cnt = s_r.init_cnt + flash_access_pkg::CNT_ONE;
        end
      end
      flash_access_pkg::TB_ON: begin
        if (wr_tb && !wdata[flash_access_pkg::TB_EN_BIT]) begin
          s_nxt.tb = flash_access_pkg::TB_OFF;
        end
      end
    endcase
    // RULE6 - programming mode kills trace buffer
    if (s_nxt.access_size_field == flash_access_pkg::ASZ_PROG) begin
      s_nxt.tb = flash_access_pkg::TB_OFF;
    end
    // RULE22 - reserved bits read zero
    if (rd) begin
      case (addr)
        flash_access_pkg::OFS_ACCESS_SIZE: s_nxt.rdata = {6'h00, s_r.access_size_field};
        flash_access_pkg::OFS_READ_WAIT:   s_nxt.rdata = {6'h00, s_r.read_wait_field};
        flash_access_pkg::OFS_STATUS:      s_nxt.rdata = {5'h00, s_r.stat};
        flash_access_pkg::OFS_EXTRA_WAIT:  s_nxt.rdata = {5'h00, s_r.sd};
        flash_access_pkg::OFS_TRACE_CTRL:  s_nxt.rdata = {6'h00, s_r.tb == flash_access_pkg::TB_ON,
                                                          s_r.tb != flash_access_pkg::TB_OFF};
        flash_access_pkg::OFS_IRQ_ENABLE:  s_nxt.rdata = {5'h00, s_r.ie};
        flash_access_pkg::OFS_IRQ_FLAGS:   s_nxt.rdata = {5'h00, s_r.flags};
        default:                           s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // RULE26 - synchronous reset values
  always_ff @(posedge clock) begin
    if (srst) begin
      // RULE1 - read mode after reset
      s_r.access_size_field       <= flash_access_pkg::ASZ_RESET;
      s_r.read_wait_field       <= flash_access_pkg::RWT_RESET;
      s_r.sd        <= flash_access_pkg::SD_RESET;
      s_r.ie        <= flash_access_pkg::IE_RESET;
      s_r.flags     <= flash_access_pkg::FLAG_RESET;
      s_r.stat      <= 3'h0;
      s_r.stat_prev <= 3'h0;
      s_r.tb        <= flash_access_pkg::TB_OFF;
      s_r.init_cnt  <= flash_access_pkg::CNT_ZERO;
      s_r.inval     <= 1'b0;
      s_r.rdata     <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign prog_mode = (s_r.access_size_field == flash_access_pkg::ASZ_PROG);
  assign rom_mode  = (s_r.access_size_field == flash_access_pkg::ASZ_ROM);
  // RULE9 - read wait gated by read mode
  assign accel_sel = rom_mode && ((s_r.read_wait_field == flash_access_pkg::RWT_ACC0) ||
                                  (s_r.read_wait_field == flash_access_pkg::RWT_ACC1));
  assign zero_sel  = rom_mode && (s_r.read_wait_field == flash_access_pkg::RWT_ZERO);
  assign read_wait_mode = rom_mode ? s_r.read_wait_field : flash_access_pkg::RWT_ZERO;
  // RULE17 - extra waits only in zero-wait
  assign extra_wait_count = zero_sel ? s_r.sd : 3'h0;
  // RULE19 - prefetch independent of trace init
  assign prefetch_enable = accel_sel;
  // RULE10 - data buffer in accelerator modes
  assign data_buf_enable     = accel_sel;
  assign data_buf_invalidate = s_r.inval;
  assign trace_buf_init      = (s_r.tb == flash_access_pkg::TB_INIT);
  assign trace_buf_active    = (s_r.tb == flash_access_pkg::TB_ON);
  // RULE21 - flag and enable gate
  assign irq_sources = s_r.flags & s_r.ie;
  assign flash_irq   = |irq_sources;
  assign rdata       = s_r.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [10:0] en_age;

  always_ff @(posedge clock) begin
    if (srst || (s_r.tb == flash_access_pkg::TB_OFF)) begin
      en_age <= 11'h000;
    end else if (en_age != 11'h7FF) begin
      en_age <= en_age + 11'h001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // RULE1 - reset to read mode
  a_reset_rom_mode: assert property ($past(srst) |-> rom_mode && read_wait_mode == 2'h3) // RULE1
    else $error("access size or read wait not at reset value");
  // RULE2 - programming code decode
  a_prog_decode: assert property (wr_asz && (wdata[1:0] == flash_access_pkg::ASZ_PROG) |=> // RULE2
                                  prog_mode && !rom_mode)
    else $error("programming code not decoded");
  // RULE2 - configuration holds
  a_cfg_hold: assert property (!wr_asz && !wr_rwt |=> $stable(s_r.access_size_field) && $stable(s_r.read_wait_field)) // RULE2
    else $error("mode configuration changed without a write");
  // RULE6 - trace off in programming
  a_prog_trace_off: assert property (prog_mode |-> !trace_buf_init && !trace_buf_active) // RULE6
    else $error("trace buffer running in programming mode");
  // RULE7 - read wait store
  a_rwt_store: assert property (wr_rwt |=> s_r.read_wait_field == $past(wdata[1:0])) // RULE7
    else $error("read wait field not stored");
  // RULE9 - read wait idle in programming
  a_prog_gate: assert property (prog_mode |-> read_wait_mode == flash_access_pkg::RWT_ZERO && // RULE9
                                extra_wait_count == 3'h0 && !data_buf_enable)
    else $error("read wait acting in programming mode");
  // RULE10 - data buffer modes
  a_dbuf_enable: assert property (data_buf_enable |-> rom_mode && s_r.read_wait_field[1]) // RULE10
    else $error("data buffer enabled outside accelerator mode");
  // RULE11 - ECC set and clear
  a_ecc_set_clear: assert property ((ecc_corr_event |=> s_r.stat[2]) and // RULE11
                                    (wr_stat && !wdata[2] && !ecc_corr_event |=> !s_r.stat[2]))
    else $error("ECC status bit set or clear wrong");
  // RULE11 - ECC kept on one
  a_ecc_keep: assert property (s_r.stat[2] && !(wr_stat && !wdata[2]) |=> s_r.stat[2]) // RULE11
    else $error("ECC status bit lost without a clear");
  // RULE12 - hang follows array
  a_hang_follow: assert property (s_r.stat[1] == $past(hang_in)) // RULE12
    else $error("hang status does not follow array");
  // RULE14 - ready follows array
  a_ready_follow: assert property (s_r.stat[0] == $past(ready_in)) // RULE14
    else $error("ready status does not follow array");
  // RULE16 - extra wait store
  a_sd_store: assert property (wr_sd |=> s_r.sd == $past(wdata[2:0])) // RULE16
    else $error("extra wait field not stored");
  // RULE17 - extra waits gated
  a_wait_gate: assert property ((extra_wait_count != 3'h0) |-> zero_sel && !data_buf_enable) // RULE17
    else $error("extra waits outside zero-wait mode");
  // RULE18 - init length
  a_trace_init_len: assert property ((s_r.tb != flash_access_pkg::TB_OFF) |-> // RULE18
                                     (trace_buf_active == (en_age >= flash_access_pkg::TRACE_INIT_CYCLES)))
    else $error("trace buffer status timing wrong");
  // RULE18 - enable write starts
  a_trace_start: assert property (wr_tb && wdata[0] && !prog_mode |=> trace_buf_init || trace_buf_active) // RULE18
    else $error("enable write did not start trace buffer");
  // RULE19 - tracing keeps running
  a_trace_keep: assert property (trace_buf_active && !wr_tb && !wr_asz |=> trace_buf_active) // RULE19
    else $error("trace buffer stopped on its own");
  // RULE20 - enable zero stops
  a_trace_stop: assert property (wr_tb && !wdata[0] |=> !trace_buf_init && !trace_buf_active) // RULE20
    else $error("enable write of zero did not stop trace buffer");
  // RULE21 - interrupt gate
  a_irq_gate: assert property (flash_irq == |(s_r.flags & s_r.ie)) // RULE21
    else $error("interrupt not gated by enable");
  // RULE21 - enable store
  a_ie_store: assert property (wr_ie |=> s_r.ie == $past(wdata[2:0])) // RULE21
    else $error("interrupt enables not stored");
  // RULE21 - interrupt follows new flag
  a_irq_raise: assert property ($rose(s_r.stat[2]) && s_r.ie[2] && !wr_ie |=> flash_irq && irq_sources[2]) // RULE21
    else $error("ECC interrupt not raised");
  // RULE22 - reserved bits read zero
  a_reserved_read: assert property ($past(rd) |-> rdata[7:3] == 5'h00) // RULE22
    else $error("reserved read bits not zero");
  // RULE22 - read data window
  a_read_window: assert property (!$past(rd) |-> rdata == 8'h00) // RULE22
    else $error("read data outside its cycle");
  // RULE23 - hang flag edge
  a_flag_rise: assert property ($rose(s_r.stat[1]) |=> s_r.flags[1]) // RULE23
    else $error("hang flag missed a rising edge");
  // RULE24 - ready flag clear
  a_flag_clear: assert property (wr_clr && wdata[0] && !(s_r.stat[0] && !s_r.stat_prev[0]) |=> // RULE24
                                 !s_r.flags[0])
    else $error("ready flag not cleared");
  // RULE24 - clear register reads zero
  a_clear_read: assert property ($past(rd) && ($past(addr) == flash_access_pkg::OFS_IRQ_CLEAR) |-> // RULE24
                                 rdata == 8'h00)
    else $error("clear register read not zero");
  // RULE25 - invalidate on rewrite
  a_buf_inval: assert property ((wr_asz || wr_rwt) |=> data_buf_invalidate) // RULE25
    else $error("data buffer not invalidated");
  // RULE25 - invalidate only after rewrite
  a_inval_pulse: assert property (data_buf_invalidate |-> $past(wr_asz || wr_rwt)) // RULE25
    else $error("data buffer invalidated without a rewrite");

  // Per-source flag edge and hold
  for (genvar g = 0; g < flash_access_pkg::NUM_SRC; g++) begin : g_flag_chk
    // RULE23 - edge sets flag
    a_flag_edge: assert property (s_r.stat[g] && !s_r.stat_prev[g] |=> s_r.flags[g]) // RULE23
      else $error("flag missed a rising edge");
    // RULE24 - flag holds until cleared
    a_flag_hold: assert property (s_r.flags[g] && !(wr_clr && wdata[g]) |=> s_r.flags[g]) // RULE24
      else $error("flag lost without a clear");
  end

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_trace_on:   cover property ($rose(trace_buf_active));
  c_ecc_irq:    cover property ($rose(irq_sources[2]));
  c_prog_entry: cover property ($rose(prog_mode));
  c_hang_irq:   cover property ($rose(irq_sources[1]));
  c_buf_inval:  cover property (data_buf_invalidate);

endmodule // flash_access_control

// ### testbench/flash_array_model.sv
// Flash array model: busy after start or reset, latched hang, ECC pulses
`timescale 1ns/1ps
module flash_array_model #(
  parameter int BUSY = 64
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // Bench controls
  input  wire logic op_start,
  input  wire logic hang_req,
  input  wire logic ecc_req,
  // Status towards the register bank
  output logic      ready_in,
  output logic      hang_in,
  output logic      ecc_corr_event
);
  int   busy_cnt = BUSY;
  logic hang_r   = 1'b0;
  always_ff @(posedge clock) begin
    if (srst || op_start) begin
      busy_cnt <= BUSY;
    end else if (busy_cnt != 0) begin
      busy_cnt <= busy_cnt - 1;
    end
  end
  always_ff @(posedge clock) begin
    if (srst || op_start) begin
      hang_r <= 1'b0;
    end else if (hang_req) begin
      hang_r <= 1'b1;
    end
  end
  assign ready_in       = (busy_cnt == 0);
  assign hang_in        = hang_r;
  assign ecc_corr_event = ecc_req;
endmodule // flash_array_model

// ### testbench/flash_access_control_tb.sv
// Self-checking bench for the flash access control register bank
`timescale 1ns/1ps
module flash_access_control_tb;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       op_start = 1'b0;
  logic       hang_req = 1'b0;
  logic       ecc_req = 1'b0;
  logic [7:0] rdata;
  logic       ecc_corr_event, hang_in, ready_in, prog_mode, rom_mode, prefetch_enable;
  logic       data_buf_enable, data_buf_invalidate, trace_buf_init, trace_buf_active, flash_irq;
  logic [1:0] read_wait_mode;
  logic [2:0] extra_wait_count, irq_sources;
  int         n_errors = 0;
  int         cmp_count = 0;
  logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  logic [7:0] rst [9] = '{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] sdc [5] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h07};
  logic [7:0] rwc [3] = '{8'h00, 8'h02, 8'h03};

  flash_access_control DUT (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ecc_corr_event(ecc_corr_event), .hang_in(hang_in), .ready_in(ready_in),
    .prog_mode(prog_mode), .rom_mode(rom_mode), .read_wait_mode(read_wait_mode),
    .extra_wait_count(extra_wait_count), .prefetch_enable(prefetch_enable),
    .data_buf_enable(data_buf_enable), .data_buf_invalidate(data_buf_invalidate),
    .trace_buf_init(trace_buf_init), .trace_buf_active(trace_buf_active),
    .irq_sources(irq_sources), .flash_irq(flash_irq));

  flash_array_model ARRAY (.clock(clock), .srst(srst), .op_start(op_start), .hang_req(hang_req),
    .ecc_req(ecc_req), .ready_in(ready_in), .hang_in(hang_in), .ecc_corr_event(ecc_corr_event));

  // ----------------------------------------------------------------
  // Bus tasks and checking
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdata, exp);
  endtask

  // Source: 0 algorithm start, 1 hang, 2 ECC correction
  task automatic pulse(input int which);
    @(posedge clock);
    op_start <= (which == 0);
    hang_req <= (which == 1);
    ecc_req  <= (which == 2);
    @(posedge clock);
    op_start <= 1'b0;
    hang_req <= 1'b0;
    ecc_req  <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    foreach (ofs[i]) rchk(ofs[i], rst[i]);
    wr_reg(8'h0C, 8'h07);
    foreach (rwc[i]) begin
      wr_reg(8'h04, rwc[i]);
      chk("inval", {7'h0, data_buf_invalidate}, 8'h01);
      chk("rwm", {6'h0, read_wait_mode}, rwc[i]);
      chk("xw", {5'h0, extra_wait_count}, (rwc[i] == 8'h00) ? 8'h07 : 8'h00);
      chk("dbuf", {7'h0, data_buf_enable}, {7'h0, rwc[i] != 8'h00});
      rchk(8'h04, rwc[i]);
    end
    wr_reg(8'h04, 8'h00);
    foreach (sdc[i]) begin
      wr_reg(8'h0C, sdc[i]);
      chk("xw", {5'h0, extra_wait_count}, sdc[i]);
    end
    wr_reg(8'h04, 8'hFE);
    rchk(8'h04, 8'h02);
    wr_reg(8'h10, 8'h01);
    rchk(8'h10, 8'h01);
    chk("pref", {7'h0, prefetch_enable}, 8'h01);
    chk("init", {7'h0, trace_buf_init}, 8'h01);
    repeat (1022) @(posedge clock);
    #1;
    chk("active", {7'h0, trace_buf_active}, 8'h00);
    @(posedge clock);
    #1;
    chk("active", {7'h0, trace_buf_active}, 8'h01);
    rchk(8'h10, 8'h03);
    wr_reg(8'h10, 8'h00);
    rchk(8'h10, 8'h00);
    wr_reg(8'h10, 8'h01);
    wr_reg(8'h00, 8'h01);
    chk("modes", {prog_mode, rom_mode, trace_buf_init, prefetch_enable, 2'h0, read_wait_mode},
      8'h80);
    rchk(8'h10, 8'h00);
    wr_reg(8'h00, 8'h02);
    rchk(8'h00, 8'h02);
    wr_reg(8'h1C, 8'h07);
    wr_reg(8'h14, 8'h07);
    pulse(2);
    rchk(8'h08, 8'h05);
    rchk(8'h18, 8'h04);
    chk("irq", {irq_sources, 4'h0, flash_irq}, 8'h81);
    wr_reg(8'h08, 8'h04);
    rchk(8'h08, 8'h05);
    wr_reg(8'h08, 8'h00);
    rchk(8'h08, 8'h01);
    wr_reg(8'h1C, 8'h03);
    rchk(8'h18, 8'h04);
    wr_reg(8'h1C, 8'h04);
    rchk(8'h18, 8'h00);
    pulse(1);
    wr_reg(8'h08, 8'hFF);
    rchk(8'h08, 8'h03);
    chk("irq", {irq_sources, 4'h0, flash_irq}, 8'h41);
    wr_reg(8'h14, 8'h00);
    chk("irq", {7'h0, flash_irq}, 8'h00);
    rchk(8'h1C, 8'h00);
    pulse(0);
    wr_reg(8'h1C, 8'h07);
    rchk(8'h08, 8'h00);
    rchk(8'h08, 8'h00);
    repeat (70) @(posedge clock);
    rchk(8'h08, 8'h01);
    rchk(8'h18, 8'h01);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rchk(8'h04, 8'h03);
    rchk(8'h18, 8'h00);
    rchk(8'h08, 8'h00);
    finish_test();
  end
endmodule // flash_access_control_tb
